// File: hdl/dafc_pkg.sv
// constants for the auxiliary frequency-command block
// assumes frequencies in 0.01 hz units, times in 0.1 s units
package dafc_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int TENTH_S_NS = 100_000_000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TENTH_S_CYCLES = TENTH_S_NS / CLK_PERIOD_NS;
    localparam int HOUR_TENTHS = 36000;
    // ------------------------------------------------------------
    // defaults and codes
    // ------------------------------------------------------------
    localparam logic [15:0] JOG_FREQ_RESET = 16'h00c8;
    localparam logic [15:0] JOG_TIME_RESET = 16'h00c8;
    localparam logic [15:0] DETECT_FREQ_RESET = 16'h1388;
    localparam logic [9:0] DETECT_HYST_RESET = 10'h032;
    localparam logic [10:0] DROOP_MAX = 11'h3e8;
    localparam logic [15:0] HOURS_MAX = 16'hfde8;
    localparam logic [1:0] LOW_RUN_LIMIT = 2'h0;
    localparam logic [1:0] LOW_STOP = 2'h1;
    localparam logic [1:0] LOW_ZERO = 2'h2;
    localparam logic [15:0] PERMILLE_FULL = 16'h03e8;
    localparam logic [15:0] DROOP_FULL = 16'h2710;
    typedef enum logic [2:0] {
        DIR_IDLE = 3'b001,
        DIR_RUN = 3'b010,
        DIR_DEAD = 3'b100
    } dafc_dir_type;
endpackage

// File: hdl/dafc_ramp.sv
// linear ramp generator: moves an output toward a target
// assumes step rate is set by per-tenth-second ticks from the parent
`timescale 1ns/100ps
`default_nettype none
module dafc_ramp
    import dafc_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic [WIDTH-1:0] target,
    input wire logic [WIDTH-1:0] full_scale,
    input wire logic [15:0] acc_time,
    input wire logic [15:0] dec_time,
    output logic [WIDTH-1:0] level
);
    initial begin
        if (WIDTH < 8 || WIDTH > 24) $error("ramp width out of range");
    end
    // ------------------------------------------------------------
    // per-tick step: full scale over the ramp time
    // ------------------------------------------------------------
    logic [WIDTH-1:0] level_reg, level_next;
    logic [WIDTH-1:0] step;
    logic [15:0] t;
    always_comb begin
        t = (target > level_reg) ? acc_time : dec_time;
        // zero time means an immediate jump
        if (t == 16'h0000) begin
            step = full_scale;
        end else begin
            step = WIDTH'(full_scale / t);
            if (step == '0) step = WIDTH'(1);
        end
        level_next = level_reg;
        if (tick || t == 16'h0000) begin
            if (target > level_reg) begin
                level_next = (target - level_reg > step) ?
                    WIDTH'(level_reg + step) : target;
            end else if (target < level_reg) begin
                level_next = (level_reg - target > step) ?
                    WIDTH'(level_reg - step) : target;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            level_reg <= '0;
        end else begin
            level_reg <= level_next;
        end
    end
    assign level = level_reg;
endmodule
`default_nettype wire

// File: hdl/dafc_top.sv
// auxiliary frequency-command logic of a motor drive
// assumes synchronous inputs; frequencies 0.01 hz, times 0.1 s units
`timescale 1ns/100ps
`default_nettype none
module dafc_top
    import dafc_pkg::*;
#(
    parameter int FW = 16,
    parameter int TICK_CYCLES = TENTH_S_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic run_cmd,
    input wire logic reverse_cmd,
    input wire logic jog_cmd,
    input wire logic fault_reset,
    input wire logic [1:0] accel_group_sel,
    input wire logic [FW-1:0] set_freq,
    input wire logic [FW-1:0] max_freq,
    input wire logic [FW-1:0] lower_limit,
    input wire logic [FW-1:0] jog_freq,
    input wire logic [15:0] jog_acc_time,
    input wire logic [15:0] jog_dec_time,
    input wire logic [15:0] acc_time [4],
    input wire logic [15:0] dec_time [4],
    input wire logic [FW-1:0] skip_point_one,
    input wire logic [FW-1:0] skip_point_two,
    input wire logic [FW-1:0] skip_band,
    input wire logic [15:0] dead_zone_time,
    input wire logic reverse_inhibit,
    input wire logic [1:0] low_limit_mode,
    input wire logic [10:0] droop_rate,
    input wire logic [9:0] load_permille,
    input wire logic [15:0] power_on_hour_threshold,
    input wire logic [15:0] running_hour_threshold,
    input wire logic [15:0] power_on_hours_saved,
    input wire logic [15:0] running_hours_saved,
    input wire logic startup_protect,
    input wire logic [FW-1:0] frequency_detect_level_one,
    input wire logic [9:0] detect_hysteresis_percent,
    output logic [FW-1:0] out_freq,
    output logic out_reverse,
    output logic running,
    output logic threshold_output_terminal,
    output logic power_on_time_reached_fault,
    output logic frequency_detect_out,
    output logic [15:0] accumulated_power_on_hours,
    output logic [15:0] accumulated_running_hours
);
    initial begin
        if (FW < 8 || FW > 24) $error("frequency width out of range");
        if (TICK_CYCLES < 1) $error("tick count must be positive");
    end
    // ------------------------------------------------------------
    // tenth-second tick and hour prescalers
    // ------------------------------------------------------------
    logic [31:0] tick_cnt_reg, tick_cnt_next;
    logic tick;
    logic [15:0] pon_tenth_reg, pon_tenth_next;
    logic [15:0] run_tenth_reg, run_tenth_next;
    logic [15:0] pon_hr_reg, pon_hr_next, run_hr_reg, run_hr_next;
    logic loaded_reg, pon_flt_reg, pon_flt_next;
    logic pon_hit_reg, pon_hit_next, run_hit_reg, run_hit_next;
    always_comb begin
        tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
        tick_cnt_next = tick ? 32'h0 : tick_cnt_reg + 32'h1;
        pon_tenth_next = pon_tenth_reg;
        run_tenth_next = run_tenth_reg;
        pon_hr_next = pon_hr_reg;
        run_hr_next = run_hr_reg;
        pon_hit_next = pon_hit_reg;
        run_hit_next = run_hit_reg;
        pon_flt_next = pon_flt_reg;
        // clear first, so an hour step in the same cycle still sets it
        if (fault_reset) pon_flt_next = 1'b0;
        // counts start from the values kept across power cycles
        if (!loaded_reg) begin
            pon_hr_next = power_on_hours_saved;
            run_hr_next = running_hours_saved;
        end else if (tick) begin
            pon_tenth_next = pon_tenth_reg + 16'h1;
            if (pon_tenth_reg == 16'(HOUR_TENTHS - 1)) begin
                pon_tenth_next = 16'h0;
                if (pon_hr_reg != HOURS_MAX) begin
                    pon_hr_next = pon_hr_reg + 16'h1;
                end
                // threshold 0 leaves the check off
                pon_hit_next = (power_on_hour_threshold != 16'h0) &&
                    (pon_hr_next > power_on_hour_threshold);
                if ((power_on_hour_threshold != 16'h0) &&
                    (pon_hr_next >= power_on_hour_threshold)) begin
                    pon_flt_next = 1'b1;
                end
            end
            if (running) begin
                run_tenth_next = run_tenth_reg + 16'h1;
                if (run_tenth_reg == 16'(HOUR_TENTHS - 1)) begin
                    run_tenth_next = 16'h0;
                    if (run_hr_reg != HOURS_MAX) begin
                        run_hr_next = run_hr_reg + 16'h1;
                    end
                    run_hit_next = (running_hour_threshold != 16'h0) &&
                        (run_hr_next >= running_hour_threshold);
                end
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tick_cnt_reg <= 32'h0;
            pon_tenth_reg <= 16'h0;
            run_tenth_reg <= 16'h0;
            pon_hr_reg <= 16'h0;
            run_hr_reg <= 16'h0;
            loaded_reg <= 1'b0;
            pon_hit_reg <= 1'b0;
            run_hit_reg <= 1'b0;
            pon_flt_reg <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            pon_tenth_reg <= pon_tenth_next;
            run_tenth_reg <= run_tenth_next;
            pon_hr_reg <= pon_hr_next;
            run_hr_reg <= run_hr_next;
            loaded_reg <= 1'b1;
            pon_hit_reg <= pon_hit_next;
            run_hit_reg <= run_hit_next;
            pon_flt_reg <= pon_flt_next;
        end
    end
    // ------------------------------------------------------------
    // start-up run protection
    // ------------------------------------------------------------
    logic blocked_reg, blocked_next, first_reg;
    logic run_ok;
    always_comb begin
        blocked_next = blocked_reg;
        if (startup_protect && run_cmd && (!first_reg || fault_reset)) begin
            blocked_next = 1'b1;
        end else if (!run_cmd) begin
            blocked_next = 1'b0;
        end
        run_ok = (run_cmd || jog_cmd) && !blocked_next && !pon_flt_reg;
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            blocked_reg <= 1'b0;
            first_reg <= 1'b0;
        end else begin
            blocked_reg <= blocked_next;
            first_reg <= 1'b1;
        end
    end
    // ------------------------------------------------------------
    // target shaping: skip, lower limit, jog
    // ------------------------------------------------------------
    function automatic logic [FW-1:0] skip_fix(input logic [FW-1:0] f,
        input logic [FW-1:0] pt, input logic [FW-1:0] band,
        input logic [FW-1:0] now);
        logic [FW:0] lo, hi;
        lo = (pt > (band >> 1)) ? {1'b0, pt - (band >> 1)} : '0;
        hi = {1'b0, pt} + {1'b0, band >> 1};
        skip_fix = f;
        if (pt != '0 && {1'b0, f} > lo && {1'b0, f} < hi) begin
            // approaching from below parks low, from above parks high
            skip_fix = (now <= pt) ? lo[FW-1:0] : hi[FW-1:0];
        end
    endfunction
    logic [FW-1:0] target, shaped, ramp_level, droop_cut;
    logic [15:0] ramp_acc, ramp_dec;
    logic stop_req;
    logic [FW+15:0] droop_prod;
    always_comb begin
        shaped = skip_fix(skip_fix(set_freq, skip_point_one, skip_band,
            ramp_level), skip_point_two, skip_band, ramp_level);
        stop_req = 1'b0;
        if (set_freq < lower_limit) begin
            case (low_limit_mode)
                LOW_RUN_LIMIT: shaped = lower_limit;
                LOW_STOP: stop_req = 1'b1;
                LOW_ZERO: shaped = '0;
                default: shaped = lower_limit;
            endcase
        end
        ramp_acc = acc_time[accel_group_sel];
        ramp_dec = dec_time[accel_group_sel];
        if (jog_cmd) begin
            shaped = jog_freq;
            stop_req = 1'b0;
            ramp_acc = jog_acc_time;
            ramp_dec = jog_dec_time;
        end
    end
    // ------------------------------------------------------------
    // direction control with dead zone
    // ------------------------------------------------------------
    dafc_dir_type dir_reg, dir_next;
    logic rev_reg, rev_next;
    logic [15:0] dead_reg, dead_next;
    logic want_rev;
    always_comb begin
        want_rev = reverse_cmd && !jog_cmd ? !reverse_inhibit : 1'b0;
        if (jog_cmd) want_rev = reverse_cmd && !reverse_inhibit;
        dir_next = dir_reg;
        rev_next = rev_reg;
        dead_next = dead_reg;
        target = '0;
        case (dir_reg)
            DIR_IDLE: begin
                if (run_ok && !stop_req) begin
                    rev_next = want_rev;
                    dir_next = DIR_RUN;
                end
            end
            DIR_RUN: begin
                if (!run_ok || stop_req) begin
                    if (ramp_level == '0) dir_next = DIR_IDLE;
                end else if (want_rev != rev_reg) begin
                    if (ramp_level == '0) begin
                        dead_next = 16'h0;
                        dir_next = DIR_DEAD;
                    end
                end else begin
                    target = shaped;
                end
            end
            DIR_DEAD: begin
                // output held at zero while the dead-zone time elapses
                if (tick) dead_next = dead_reg + 16'h1;
                if (dead_reg >= dead_zone_time) begin
                    rev_next = want_rev;
                    dir_next = DIR_RUN;
                end
            end
            default: dir_next = DIR_IDLE;
        endcase
        // droop cut is level * rate * load, rate in 0.01 %
        droop_prod = (FW+16)'(ramp_level) * (FW+16)'(droop_rate) *
            (FW+16)'(load_permille);
        droop_cut = FW'(droop_prod / (FW+16)'(DROOP_FULL * 1000));
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dir_reg <= DIR_IDLE;
            rev_reg <= 1'b0;
            dead_reg <= 16'h0;
        end else begin
            dir_reg <= dir_next;
            rev_reg <= rev_next;
            dead_reg <= dead_next;
        end
    end
    dafc_ramp #(.WIDTH(FW)) u_ramp (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .tick(tick),
        .target(target),
        .full_scale(max_freq),
        .acc_time(ramp_acc),
        .dec_time(ramp_dec),
        .level(ramp_level)
    );
    // ------------------------------------------------------------
    // outputs and frequency detection
    // ------------------------------------------------------------
    logic [FW-1:0] freq_reg, freq_next;
    logic det_reg, det_next;
    logic [FW+9:0] hyst_prod;
    logic [FW-1:0] off_level;
    always_comb begin
        freq_next = (droop_rate > DROOP_MAX || droop_cut > ramp_level) ?
            ramp_level : ramp_level - droop_cut;
        // hysteresis in 0.1 % of the detection level
        hyst_prod = (FW+10)'(frequency_detect_level_one) *
            (FW+10)'(detect_hysteresis_percent);
        off_level = frequency_detect_level_one -
            FW'(hyst_prod / (FW+10)'(PERMILLE_FULL));
        det_next = det_reg;
        if (freq_reg > frequency_detect_level_one) det_next = 1'b1;
        else if (freq_reg < off_level) det_next = 1'b0;
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            freq_reg <= '0;
            det_reg <= 1'b0;
        end else begin
            freq_reg <= freq_next;
            det_reg <= det_next;
        end
    end
    assign out_freq = freq_reg;
    assign out_reverse = rev_reg;
    assign running = (dir_reg != DIR_IDLE);
    assign threshold_output_terminal = pon_hit_reg || run_hit_reg;
    assign power_on_time_reached_fault = pon_flt_reg;
    assign frequency_detect_out = det_reg;
    assign accumulated_power_on_hours = pon_hr_reg;
    assign accumulated_running_hours = run_hr_reg;
endmodule
`default_nettype wire

// File: tb/dafc_assertions.sv
// checker for the auxiliary frequency-command block
// assumes it is bound onto dafc_top, single clock domain
`timescale 1ns/100ps
`default_nettype none
module dafc_assertions
    import dafc_pkg::*;
#(
    parameter int FW = 16,
    parameter int TICK_CYCLES = 10
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic run_cmd,
    input wire logic fault_reset,
    input wire logic startup_protect,
    input wire logic reverse_inhibit,
    input wire logic [15:0] dead_zone_time,
    input wire logic [15:0] power_on_hour_threshold,
    input wire logic [15:0] running_hour_threshold,
    input wire logic [FW-1:0] frequency_detect_level_one,
    input wire logic [9:0] detect_hysteresis_percent,
    input wire logic [FW-1:0] out_freq,
    input wire logic out_reverse,
    input wire logic running,
    input wire logic threshold_output_terminal,
    input wire logic power_on_time_reached_fault,
    input wire logic frequency_detect_out,
    input wire logic [15:0] accumulated_power_on_hours,
    input wire logic [15:0] accumulated_running_hours
);
    int off_lvl, need_zero, zero_reg, zero_next;
    logic guard_reg, guard_next;
    // ------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------
    always_comb begin
        off_lvl = int'(frequency_detect_level_one);
        off_lvl = off_lvl - off_lvl * int'(detect_hysteresis_percent) / 1000;
        // tick phase may eat up to one tick of the dead zone
        need_zero = (int'(dead_zone_time) - 1) * TICK_CYCLES;
        zero_next = (out_freq == '0) ? zero_reg + 1 : 0;
        guard_next = (guard_reg && run_cmd) || (startup_protect
            && power_on_time_reached_fault && fault_reset);
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            zero_reg <= 0;
            guard_reg <= startup_protect;
        end else begin
            zero_reg <= zero_next;
            guard_reg <= guard_next;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    chk_detect_on: assert property (
        $rose(frequency_detect_out) |-> out_freq > frequency_detect_level_one
        || $past(out_freq) > $past(frequency_detect_level_one))
        else $error("detect rose at or below level");
    chk_detect_off: assert property (
        $fell(frequency_detect_out) |-> int'(out_freq) < off_lvl
        || $past(int'(out_freq) < off_lvl))
        else $error("detect fell above hysteresis level");
    chk_reverse_blocked: assert property (
        reverse_inhibit && !out_reverse |=> !out_reverse)
        else $error("reverse while inhibited");
    chk_dead_zone: assert property (
        $changed(out_reverse) |-> $past(out_freq) == '0
        && zero_reg >= need_zero)
        else $error("direction changed without dead zone");
    chk_run_guard: assert property (
        guard_reg && run_cmd |-> !running)
        else $error("run accepted while protected");
    chk_fault_hours: assert property (
        $rose(power_on_time_reached_fault) |-> power_on_hour_threshold != 0
        && accumulated_power_on_hours >= power_on_hour_threshold
        && $past(accumulated_power_on_hours, 2) != accumulated_power_on_hours)
        else $error("fault without threshold hour");
    chk_terminal_cause: assert property (
        $rose(threshold_output_terminal) |-> (power_on_hour_threshold != 0
        && accumulated_power_on_hours >= power_on_hour_threshold)
        || (running_hour_threshold != 0
        && accumulated_running_hours >= running_hour_threshold))
        else $error("terminal on below thresholds");
    chk_hour_step: assert property (
        $past(rst_n, 2) && $changed(accumulated_power_on_hours) |->
        accumulated_power_on_hours == $past(accumulated_power_on_hours) + 1)
        else $error("power-on hours not stepped by one");
    cover property ($rose(frequency_detect_out));
    cover property ($rose(power_on_time_reached_fault));
    cover property ($changed(out_reverse));
endmodule
bind dafc_top dafc_assertions #(.FW(FW), .TICK_CYCLES(TICK_CYCLES))
    u_dafc_assertions (.*);
`default_nettype wire

// File: tb/dafc_drive_model.sv
// drive-side partner: motor load and nonvolatile hour store
// assumes hour counters only grow while powered
`timescale 1ns/100ps
`default_nettype none
module dafc_drive_model #(
    parameter logic [15:0] ON_SEED = 16'h0004,
    parameter logic [15:0] RUN_SEED = 16'h0002,
    parameter logic [9:0] LOAD = 10'h3e8
) (
    input wire logic ref_clk,
    input wire logic [15:0] out_freq,
    input wire logic [15:0] accumulated_power_on_hours,
    input wire logic [15:0] accumulated_running_hours,
    output logic [9:0] load_permille,
    output logic [15:0] power_on_hours_saved,
    output logic [15:0] running_hours_saved
);
    initial power_on_hours_saved = ON_SEED;
    initial running_hours_saved = RUN_SEED;
    // keep the highest count, so a reset zeroing the live counters
    // never wipes the store
    always @(posedge ref_clk) begin
        if (accumulated_power_on_hours > power_on_hours_saved)
            power_on_hours_saved <= accumulated_power_on_hours;
        if (accumulated_running_hours > running_hours_saved)
            running_hours_saved <= accumulated_running_hours;
    end
    // rated load only while the shaft turns
    assign load_permille = (out_freq != 16'h0) ? LOAD : 10'h0;
endmodule
`default_nettype wire

// File: tb/dafc_top_test.sv
// self-checking bench for the frequency-command block
// assumes tick of one clock, so an hour is 36000 cycles
`timescale 1ns/100ps
`default_nettype none
module dafc_top_test;
    import dafc_pkg::*;
    logic ref_clk, rst_n, run_cmd, reverse_cmd, jog_cmd, fault_reset;
    logic reverse_inhibit, startup_protect, out_reverse, running;
    logic [1:0] accel_group_sel, low_limit_mode;
    logic [15:0] set_freq, max_freq, lower_limit, jog_freq, jog_acc_time;
    logic [15:0] jog_dec_time, skip_point_one, skip_point_two, skip_band;
    logic [15:0] dead_zone_time, power_on_hour_threshold, out_freq;
    logic [15:0] running_hour_threshold, frequency_detect_level_one;
    logic [15:0] acc_time [4], dec_time [4];
    logic [10:0] droop_rate;
    logic [9:0] load_permille, detect_hysteresis_percent;
    logic [15:0] power_on_hours_saved, running_hours_saved;
    logic [15:0] accumulated_power_on_hours, accumulated_running_hours;
    logic threshold_output_terminal, power_on_time_reached_fault;
    logic frequency_detect_out;
    int failures, samples_checked;
    dafc_top #(.FW(16), .TICK_CYCLES(1)) u_dafc_top (.*);
    dafc_drive_model u_dafc_drive_model (.*);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // bounded wait, then judge the settled frequency
    task automatic freq_is(input logic [15:0] v);
        int i;
        for (i = 0; i < 200 && out_freq !== v; i++) cyc(1);
        check(out_freq, v);
    endtask
    task automatic rerun();
        run_cmd = 1'b0;
        cyc(2);
        run_cmd = 1'b1;
        cyc(3);
    endtask
    task automatic conclude();
        $display("checks=%0d failures=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_protect();
        cyc(10);
        check(16'(running), 16'h0);
        rerun();
        check(16'(running), 16'h1);
    endtask
    task automatic t_detect();
        logic [15:0] f [4] = '{16'h0bb8, 16'h076c, 16'h06a4, 16'h0834};
        logic [15:0] d [4] = '{16'h1, 16'h1, 16'h0, 16'h1};
        for (int k = 0; k < 4; k++) begin
            set_freq = f[k];
            freq_is(f[k]);
            cyc(2);
            check(16'(frequency_detect_out), d[k]);
        end
    endtask
    task automatic t_skip();
        set_freq = 16'h01f4;
        freq_is(16'h01f4);
        {skip_point_one, skip_band} = {16'h03e8, 16'h00c8};
        set_freq = 16'h041a;
        freq_is(16'h0384);
        set_freq = 16'h05dc;
        freq_is(16'h05dc);
        set_freq = 16'h041a;
        freq_is(16'h044c);
        {skip_point_one, skip_point_two} = {16'h0, 16'h03e8};
        set_freq = 16'h03d4;
        freq_is(16'h044c);
        skip_point_two = 16'h0;
        freq_is(16'h03d4);
    endtask
    task automatic t_lowlim();
        logic [15:0] e [3] = '{16'h0190, 16'h0, 16'h0};
        lower_limit = 16'h0190;
        for (int m = 0; m < 3; m++) begin
            low_limit_mode = m[1:0];
            set_freq = 16'h03e8;
            rerun();
            freq_is(16'h03e8);
            set_freq = 16'h012c;
            cyc(10);
            check(out_freq, e[m]);
        end
        {lower_limit, low_limit_mode} = '0;
        rerun();
    endtask
    task automatic t_groups();
        for (int g = 0; g < 4; g++) begin
            set_freq = 16'h0;
            freq_is(16'h0);
            acc_time = '{default: 16'hffff};
            acc_time[g] = 16'h0;
            accel_group_sel = g[1:0];
            cyc(1);
            set_freq = 16'h07d0;
            cyc(20);
            check(out_freq, 16'h07d0);
        end
        acc_time = '{default: 16'h0};
    endtask
    // start and stop modes are taken as direct start, ramp stop
    task automatic t_jog();
        {run_cmd, jog_acc_time} = {1'b0, 16'hffff};
        freq_is(16'h0);
        jog_cmd = 1'b1;
        cyc(20);
        check(16'(out_freq < 16'h00c8), 16'h1);
        jog_acc_time = 16'h0;
        freq_is(16'h00c8);
        {jog_cmd, run_cmd, set_freq} = {2'b01, 16'h0bb8};
    endtask
    task automatic t_droop();
        freq_is(16'h0bb8);
        droop_rate = 11'h3e8;
        freq_is(16'h0a8c);
        droop_rate = 11'h0;
        freq_is(16'h0bb8);
    endtask
    task automatic t_reverse();
        int n;
        {reverse_inhibit, reverse_cmd} = 2'b11;
        cyc(20);
        check(16'(out_reverse), 16'h0);
        check(out_freq, 16'h0bb8);
        reverse_inhibit = 1'b0;
        for (n = 0; n < 200 && out_reverse !== 1'b1; cyc(1))
            n += (out_freq === 16'h0) ? 1 : 0;
        check(16'(out_reverse), 16'h1);
        check(16'(n >= 5), 16'h1);
        freq_is(16'h0bb8);
        reverse_cmd = 1'b0;
    endtask
    task automatic t_hours();
        int i;
        {power_on_hour_threshold, running_hour_threshold} = {16'h6, 16'h3};
        for (i = 0; i < 80000 && accumulated_running_hours !== 3; i++) cyc(1);
        cyc(3);
        check(threshold_output_terminal, 16'h1);
        for (i = 0; i < 80000 && accumulated_power_on_hours !== 6; i++) cyc(1);
        cyc(3);
        check(power_on_time_reached_fault, 16'h1);
        check(threshold_output_terminal, 16'h1);
        check(16'(running), 16'h0);
    endtask
    task automatic t_fault();
        {power_on_hour_threshold, fault_reset} = {16'h0, 1'b1};
        cyc(1);
        fault_reset = 1'b0;
        cyc(5);
        check(16'(running), 16'h0);
        rerun();
        check(16'(running), 16'h1);
    endtask
    task automatic t_cycle();
        rst_n = 1'b0;
        cyc(5);
        rst_n = 1'b1;
        cyc(3);
        check(accumulated_power_on_hours, 16'h6);
        check(accumulated_running_hours, 16'h3);
        check(16'(running), 16'h0);
    endtask
    initial begin
        {run_cmd, startup_protect, rst_n, reverse_cmd, jog_cmd} = 5'b11000;
        {fault_reset, reverse_inhibit, accel_group_sel, low_limit_mode} = '0;
        {lower_limit, jog_acc_time, jog_dec_time, skip_band} = '0;
        {skip_point_one, skip_point_two, droop_rate} = '0;
        {power_on_hour_threshold, running_hour_threshold} = '0;
        acc_time = '{default: 16'h0};
        dec_time = '{default: 16'h0};
        {max_freq, jog_freq, set_freq} = {16'h1388, 16'h00c8, 16'h0bb8};
        {dead_zone_time, frequency_detect_level_one} = {16'h5, 16'h07d0};
        detect_hysteresis_percent = 10'h064;
        {failures, samples_checked} = '0;
        cyc(5);
        rst_n = 1'b1;
        t_protect();
        t_detect();
        t_skip();
        t_lowlim();
        t_groups();
        t_jog();
        t_droop();
        t_reverse();
        startup_protect = 1'b0;
        t_hours();
        startup_protect = 1'b1;
        t_fault();
        t_cycle();
        conclude();
    end
    // two hours of power plus a little slack for the other scenarios
    initial begin
        #900000;
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
